// ---- logic/brg_defines.svh ----
// Constants shared by both ends of the baud-rate generator link.
// Assumes one clock (clk, 10 MHz) and active-low asynchronous reset rst_n.
//
// Contract
// - Timer counts down; clock from divider or prescaler
// - Software keeps divider mode fractional for baud
// - Run bit starts and halts the timer
// - Underflow reloads from reload value, one pulse
// - Normal divider mode stops timer, ignores run
// - Prescaler divides by two to the field
// - Fractional mode scales input by step/256
// - Rate is clock/16/prescale/(reload+1)*step/256
// - Software keeps prescale times (reload+1) above one
// - Standard LIN rates may run without divider
// - LIN fast mode should enable the divider
`ifndef BRG_DEFINES_SVH
`define BRG_DEFINES_SVH

// Field widths
`define BRG_PRE_W       3
`define BRG_PRE_CNT_W   7
`define BRG_RELOAD_W    8
`define BRG_STEP_W      8
`define BRG_OVS_W       4
`define BRG_PULSE_W     16

// Reset values
`define BRG_RST_PRE     3'h0
`define BRG_RST_RELOAD  8'h00
`define BRG_RST_STEP    8'h00
`define BRG_RST_OVS     4'h0
`define BRG_RST_PULSES  16'h0000

// Host register map, byte addresses
`define BRG_ADDR_W      8
`define BRG_OFS_CTRL    8'h00
`define BRG_OFS_PRE     8'h04
`define BRG_OFS_STEP    8'h08
`define BRG_OFS_RELOAD  8'h0c
`define BRG_OFS_STATUS  8'h10
`define BRG_OFS_PULSES  8'h14

// Control register bits
`define BRG_CTRL_EN     0
`define BRG_CTRL_MODE   1
`define BRG_CTRL_RUN    2

// Status register bits
`define BRG_STAT_REFUSED 0
`define BRG_STAT_ACTIVE  1

`endif

// ---- logic/brg_pkg.sv ----
// Types shared by both ends of the baud-rate generator link.
// Assumes brg_defines.svh is on the include path.
`include "brg_defines.svh"

package brg_pkg;

  typedef enum logic {
    BRG_FD_FRAC   = 1'b0,
    BRG_FD_NORMAL = 1'b1
  } brg_fd_mode_t;

  typedef logic [`BRG_PRE_W-1:0]    brg_pre_t;
  typedef logic [`BRG_RELOAD_W-1:0] brg_reload_t;
  typedef logic [`BRG_STEP_W-1:0]   brg_step_t;

endpackage

// ---- logic/brg_if.sv ----
// Link between the baud-rate generator and the side that configures it.
// Assumes both ends run on the same clk; no signal needs a synchroniser.
`include "brg_defines.svh"

interface brg_if;

  logic                  frac_div_enable;
  brg_pkg::brg_fd_mode_t frac_div_mode_sel;
  logic                  baud_timer_run;
  brg_pkg::brg_pre_t     baud_prescale_sel;
  brg_pkg::brg_step_t    frac_step_reg;
  brg_pkg::brg_reload_t  baud_reload;
  logic                  baud_clk_pulse;
  logic                  timer_active;

  modport device (
    input  frac_div_enable,
    input  frac_div_mode_sel,
    input  baud_timer_run,
    input  baud_prescale_sel,
    input  frac_step_reg,
    input  baud_reload,
    output baud_clk_pulse,
    output timer_active
  );

  modport host (
    output frac_div_enable,
    output frac_div_mode_sel,
    output baud_timer_run,
    output baud_prescale_sel,
    output frac_step_reg,
    output baud_reload,
    input  baud_clk_pulse,
    input  timer_active
  );

endinterface

// ---- logic/brg_device.sv ----
// Baud-rate generator: prescaler, fractional divider and 8-bit
// count-down reload timer producing one pulse per underflow.
// Assumes configuration arrives from the host end on the same clock,
// so no input is synchronised.
`include "brg_defines.svh"

module brg_device (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  brg_if.device                           link,
  output      logic                       baud_tick,
  output      logic                       baud_bit_tick,
  output      logic [`BRG_RELOAD_W-1:0]   timer_count
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic [`BRG_PRE_CNT_W-1:0] pre_cnt;
  logic [`BRG_PRE_CNT_W-1:0] pre_mask;
  logic                      div_tick;

  logic [`BRG_STEP_W-1:0]    frac_acc;
  logic [`BRG_STEP_W:0]      frac_sum;
  logic                      frac_active;
  logic                      mod_tick;

  logic                      timer_stop;
  logic                      timer_run_eff;
  logic                      timer_clk;
  logic                      underflow;

  logic [`BRG_OVS_W-1:0]     ovs_cnt;

  ////////////////////////////////////////////////////////////////////
  // Prescaler

  // Mask of the low bits that must all be ones for a tick
  always_comb begin
    pre_mask = `BRG_PRE_CNT_W'((8'h01 << link.baud_prescale_sel) - 8'h01);
  end

  // Free-running counter; a zero mask ticks on every clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + `BRG_PRE_CNT_W'(1);
    end
  end

  // Divide by two to the field: 000 -> 1, 001 -> 2, 010 -> 4
  always_comb begin
    div_tick = ((pre_cnt & pre_mask) == pre_mask);
  end

  ////////////////////////////////////////////////////////////////////
  // Fractional divider

  always_comb begin
    frac_active = link.frac_div_enable &&
                  (link.frac_div_mode_sel == brg_pkg::BRG_FD_FRAC);
  end

  always_comb begin
    frac_sum = {1'b0, frac_acc} + {1'b0, link.frac_step_reg};
  end

  // Carry out of an 8-bit accumulator passes step of every 256 ticks
  always_comb begin
    mod_tick = div_tick && frac_active && frac_sum[`BRG_STEP_W];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frac_acc <= `BRG_RST_STEP;
    end else if (!frac_active) begin
      // Restart the phase so a re-enable behaves the same every time
      frac_acc <= `BRG_RST_STEP;
    end else if (div_tick) begin
      frac_acc <= frac_sum[`BRG_STEP_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Timer clock selection and run control

  always_comb begin
    timer_stop = link.frac_div_enable &&
                 (link.frac_div_mode_sel == brg_pkg::BRG_FD_NORMAL);
  end

  always_comb begin
    timer_run_eff = link.baud_timer_run && !timer_stop;
  end

  always_comb begin
    if (link.frac_div_enable) begin
      timer_clk = mod_tick;
    end else begin
      timer_clk = div_tick;
    end
  end

  always_comb begin
    underflow = timer_run_eff && timer_clk &&
                (timer_count == `BRG_RST_RELOAD);
  end

  ////////////////////////////////////////////////////////////////////
  // Count-down timer

  // The count is kept while halted, so a restart resumes where it stood.
  // The reload value is read only at underflow, so a new value never
  // disturbs a count already in progress.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_count <= `BRG_RST_RELOAD;
    end else if (timer_run_eff && timer_clk) begin
      if (underflow) begin
        timer_count <= link.baud_reload;
      end else begin
        timer_count <= timer_count - `BRG_RELOAD_W'(1);
      end
    end
  end

  // One pulse per underflow; period is prescale*(reload+1), scaled by
  // 256/step when the fractional divider is active
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= underflow;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Oversampling divider

  // The serial channel samples sixteen times per bit; this pulse marks
  // one bit time for observers that do not oversample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovs_cnt <= `BRG_RST_OVS;
    end else if (underflow) begin
      ovs_cnt <= ovs_cnt + `BRG_OVS_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_bit_tick <= 1'b0;
    end else begin
      baud_bit_tick <= underflow && (ovs_cnt == {`BRG_OVS_W{1'b1}});
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Link outputs

  always_comb begin
    link.baud_clk_pulse = baud_tick;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.timer_active <= 1'b0;
    end else begin
      link.timer_active <= timer_run_eff;
    end
  end

endmodule

// ---- logic/brg_host.sv ----
// Configuring end of the baud-rate generator: software registers over a
// plain strobe port, driving the generator's settings and counting pulses.
// Assumes the generator shares clk; reads answer one cycle later.
`include "brg_defines.svh"

module brg_host (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  brg_if.host                           link,
  input  wire logic [`BRG_ADDR_W-1:0]   addr,
  input  wire logic [31:0]              wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output      logic [31:0]              rdata
);

  ////////////////////////////////////////////////////////////////////
  // Registers

  logic                     fd_en;
  brg_pkg::brg_fd_mode_t    fd_mode;
  logic                     run;
  brg_pkg::brg_pre_t        pre;
  brg_pkg::brg_step_t       step;
  brg_pkg::brg_reload_t     reload;
  logic                     refused;
  logic [`BRG_PULSE_W-1:0]  pulses;
  logic                     ctrl_ok;
  logic                     pre_ok;
  logic                     reload_ok;
  logic                     bad_req;
  logic [31:0]              next_rdata;

  ////////////////////////////////////////////////////////////////////
  // Write checks

  // Normal divider mode is never combined with a running timer, and a
  // prescale of one is paired with reload zero (rate clk/16) only in the reset state
  always_comb begin
    ctrl_ok   = !(wdata[`BRG_CTRL_MODE] && wdata[`BRG_CTRL_RUN]);
    pre_ok    = !((wdata[`BRG_PRE_W-1:0] == `BRG_RST_PRE) &&
                  (reload == `BRG_RST_RELOAD));
    reload_ok = !((pre == `BRG_RST_PRE) &&
                  (wdata[`BRG_RELOAD_W-1:0] == `BRG_RST_RELOAD));
    bad_req   = wr && (((addr == `BRG_OFS_CTRL) && !ctrl_ok) ||
                       ((addr == `BRG_OFS_PRE) && !pre_ok) ||
                       ((addr == `BRG_OFS_RELOAD) && !reload_ok));
  end

  // Divider enable is free: off suits standard LIN, on suits fast mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fd_en   <= 1'b0;
      fd_mode <= brg_pkg::BRG_FD_FRAC;
      run     <= 1'b0;
    end else if (wr && (addr == `BRG_OFS_CTRL) && ctrl_ok) begin
      fd_en   <= wdata[`BRG_CTRL_EN];
      fd_mode <= brg_pkg::brg_fd_mode_t'(wdata[`BRG_CTRL_MODE]);
      run     <= wdata[`BRG_CTRL_RUN];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= `BRG_RST_PRE;
    end else if (wr && (addr == `BRG_OFS_PRE) && pre_ok) begin
      pre <= wdata[`BRG_PRE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step <= `BRG_RST_STEP;
    end else if (wr && (addr == `BRG_OFS_STEP)) begin
      step <= wdata[`BRG_STEP_W-1:0];
    end
  end

  // Reset reload is 0 with prescale 1; software must program one first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload <= `BRG_RST_RELOAD;
    end else if (wr && (addr == `BRG_OFS_RELOAD) && reload_ok) begin
      reload <= wdata[`BRG_RELOAD_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status: sticky refusal flag (set beats clear) and pulse counter (a clear keeps a coincident pulse)

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused <= 1'b0;
    end else if (bad_req) begin
      refused <= 1'b1;
    end else if (wr && (addr == `BRG_OFS_STATUS) && wdata[`BRG_STAT_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulses <= `BRG_RST_PULSES;
    end else if (wr && (addr == `BRG_OFS_PULSES)) begin
      pulses <= {{(`BRG_PULSE_W-1){1'b0}}, link.baud_clk_pulse};
    end else if (link.baud_clk_pulse) begin
      pulses <= pulses + `BRG_PULSE_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read port, unmapped addresses read zero

  always_comb begin
    next_rdata = '0;
    unique case (addr)
      `BRG_OFS_CTRL: begin
        next_rdata[`BRG_CTRL_EN]   = fd_en;
        next_rdata[`BRG_CTRL_MODE] = fd_mode;
        next_rdata[`BRG_CTRL_RUN]  = run;
      end
      `BRG_OFS_PRE:    next_rdata[`BRG_PRE_W-1:0]    = pre;
      `BRG_OFS_STEP:   next_rdata[`BRG_STEP_W-1:0]   = step;
      `BRG_OFS_RELOAD: next_rdata[`BRG_RELOAD_W-1:0] = reload;
      `BRG_OFS_STATUS: begin
        next_rdata[`BRG_STAT_REFUSED] = refused;
        next_rdata[`BRG_STAT_ACTIVE]  = link.timer_active;
      end
      `BRG_OFS_PULSES: next_rdata[`BRG_PULSE_W-1:0]  = pulses;
      default:         next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? next_rdata : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Link drive

  always_comb begin
    link.frac_div_enable   = fd_en;
    link.frac_div_mode_sel = fd_mode;
    link.baud_timer_run    = run;
    link.baud_prescale_sel = pre;
    link.frac_step_reg     = step;
    link.baud_reload       = reload;
  end

endmodule

// ---- tb/brg_asserts.sv ----
// Checker for the generator link, fed with the interface signals.
// Assumes one clock and an active-low asynchronous reset.
module brg_asserts (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  frac_div_enable,
  input wire brg_pkg::brg_fd_mode_t frac_div_mode_sel,
  input wire logic                  baud_timer_run,
  input wire brg_pkg::brg_pre_t     baud_prescale_sel,
  input wire brg_pkg::brg_step_t    frac_step_reg,
  input wire brg_pkg::brg_reload_t  baud_reload,
  input wire logic                  baud_clk_pulse,
  input wire logic                  timer_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        stop;
  int unsigned per;
  logic [16:0] gap;
  logic [1:0]  quiet;
  assign stop = frac_div_enable && frac_div_mode_sel == brg_pkg::BRG_FD_NORMAL;
  assign per  = (32'h1 << baud_prescale_sel) * (32'(baud_reload) + 32'h1);
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) gap <= 17'h0;
    else gap <= baud_clk_pulse ? 17'h1 : gap + 17'h1;
  end
  // Period is judged from the second pulse after settings settle: a count in
  // progress and a deferred reload make the first period after a change irregular
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) quiet <= 2'h0;
    else if (!baud_timer_run || frac_div_enable || !$stable(baud_prescale_sel) || !$stable(baud_reload)) quiet <= 2'h0;
    else if (baud_clk_pulse && quiet != 2'h3) quiet <= quiet + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_pulse_single: assert property (baud_clk_pulse && (baud_prescale_sel != 3'h0 || baud_reload != 8'h00)
    |=> !baud_clk_pulse) else $error("baud pulse longer than one cycle");
  a_period_exact: assert property (baud_clk_pulse && quiet != 2'h0 |-> gap == 17'(per))
    else $error("baud pulse period wrong");
  a_normal_stop: assert property (stop[*3] |-> !baud_clk_pulse && !timer_active)
    else $error("timer runs in normal divider mode");
  a_run_active: assert property (baud_timer_run && !stop |=> timer_active)
    else $error("run bit did not start timer");
  a_halt_idle: assert property ((!baud_timer_run)[*3] |-> !baud_clk_pulse && !timer_active)
    else $error("halted timer still active");
  a_step_zero: assert property ((frac_div_enable && !stop && frac_step_reg == 8'h00)[*3] |-> !baud_clk_pulse)
    else $error("pulse with zero step");
  a_mode_guard: assert property (!(frac_div_mode_sel == brg_pkg::BRG_FD_NORMAL && baud_timer_run))
    else $error("run set with normal divider mode");
  a_rate_floor: assert property ($changed(baud_prescale_sel) || $changed(baud_reload)
    |-> baud_prescale_sel != 3'h0 || baud_reload != 8'h00) else $error("rate above clock over 32");
  c_period: cover property (baud_clk_pulse && quiet != 2'h0);
  c_normal: cover property (stop[*3]);
  c_frac: cover property (frac_div_enable && !stop && baud_clk_pulse);
endmodule

// ---- tb/tb_top.sv ----
// Bench joining host and generator ends over one link interface.
// Assumes a 10 MHz clock; software port answers reads one cycle later.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        tick;
  logic        bit_tick;
  logic [7:0]  tcount;
  int          fail_count;
  int          check_count;
  brg_if link_if();
  brg_host u_brg_host (.clk(clk), .rst_n(rst_n), .link(link_if.host), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  brg_device u_brg_device (.clk(clk), .rst_n(rst_n), .link(link_if.device), .baud_tick(tick),
    .baud_bit_tick(bit_tick), .timer_count(tcount));
  brg_asserts u_brg_asserts (.clk(clk), .rst_n(rst_n), .frac_div_enable(link_if.frac_div_enable),
    .frac_div_mode_sel(link_if.frac_div_mode_sel), .baud_timer_run(link_if.baud_timer_run),
    .baud_prescale_sel(link_if.baud_prescale_sel), .frac_step_reg(link_if.frac_step_reg),
    .baud_reload(link_if.baud_reload), .baud_clk_pulse(link_if.baud_clk_pulse), .timer_active(link_if.timer_active));
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_get(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // Bounded count of cycles up to the next pulse, optionally syncing first;
  // looks only at falling edges so a pulse is never read as it is launched
  task automatic span(input bit sync, output int n);
    n = 0;
    if (sync) begin
      do begin
        @(negedge clk);
        n++;
      end while (link_if.baud_clk_pulse !== 1'b1 && n < 9000);
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (link_if.baud_clk_pulse !== 1'b1 && n < 9000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] v;
    for (int a = 0; a <= 32; a += 4) begin
      rd_get(8'(a), v);
      chk(v, 32'h0);
    end
    wr_reg(8'h0c, 32'h0);
    rd_get(8'h10, v);
    chk(v, 32'h1);
    wr_reg(8'h10, 32'h1);
    rd_get(8'h10, v);
    chk(v, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_period;
    logic [31:0] v;
    int          n;
    logic [2:0]  pre[4] = '{3'h0, 3'h1, 3'h2, 3'h0};
    logic [7:0]  rel[4] = '{8'h03, 8'h03, 8'h03, 8'h57};
    wr_reg(8'h0c, 32'h3);
    wr_reg(8'h00, 32'h4);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h04, 32'(pre[i]));
      wr_reg(8'h0c, 32'(rel[i]));
      // Two periods are thrown away: the reload in progress may still be the old one
      span(1'b1, n);
      span(1'b0, n);
      span(1'b0, n);
      chk(32'(n), (32'h1 << pre[i]) * (32'(rel[i]) + 32'h1));
      chk(32'(tick), 32'h1);
      chk(32'(tcount), 32'(rel[i]));
    end
    rd_get(8'h10, v);
    chk(v, 32'h2);
    $display("test period done");
  endtask
  task automatic t_reload;
    int n;
    wr_reg(8'h0c, 32'h0f);
    span(1'b1, n);
    span(1'b0, n);
    fork
      wr_reg(8'h0c, 32'h3);
      span(1'b0, n);
    join
    chk(32'(n), 32'd16);
    span(1'b0, n);
    chk(32'(n), 32'd4);
    n = 0;
    while (bit_tick !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (bit_tick !== 1'b1 && n < 9000);
    chk(32'(n), 32'd64);
    $display("test reload done");
  endtask
  task automatic t_frac;
    logic [31:0] v;
    wr_reg(8'h0c, 32'h1);
    wr_reg(8'h08, 32'h0);
    wr_reg(8'h00, 32'h5);
    wr_reg(8'h14, 32'h0);
    repeat (100) @(posedge clk);
    rd_get(8'h14, v);
    chk(v, 32'h0);
    wr_reg(8'h08, 32'h80);
    wr_reg(8'h14, 32'h0);
    // Step 128 halves the tick rate: one pulse per four clocks on average
    repeat (400) @(posedge clk);
    rd_get(8'h14, v);
    chk(32'(v >= 32'd98 && v <= 32'd102), 32'h1);
    $display("test frac done");
  endtask
  task automatic t_halt;
    logic [31:0] v;
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h14, 32'h0);
    repeat (200) @(posedge clk);
    rd_get(8'h14, v);
    chk(v, 32'h0);
    wr_reg(8'h00, 32'h3);
    wr_reg(8'h00, 32'h7);
    rd_get(8'h10, v);
    chk(v, 32'h1);
    rd_get(8'h00, v);
    chk(v, 32'h3);
    $display("test halt done");
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk         = 1'b0;
    rst_n       = 1'b0;
    addr        = 8'h00;
    wdata       = 32'h0;
    wr          = 1'b0;
    rd          = 1'b0;
    fail_count  = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_period();
    t_reload();
    t_frac();
    t_halt();
    results();
  end
  // Whole run needs well under 10000 cycles
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
